// ### logic/ags_pkg.sv
// package for the gain-lock and loop-table configuration block
// assumes a 32-bit axi4-lite register bus and one 125 MHz clock
package ags_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  // printed offsets 0x112 and 0x113 are not multiples of four, so all three are indices
  localparam logic [11:0] IDX_CFG = 12'h113;
  localparam logic [11:0] IDX_UPPER = 12'h112;
  localparam logic [11:0] IDX_STATUS = 12'h120;
  localparam logic [13:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [13:0] ADDR_UPPER = {IDX_UPPER, 2'b00};
  localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [5:0] UPPER_RESET = 6'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LOCK_MSB = 7;
  localparam int LOCK_LSB = 6;
  localparam int SEL_MSB = 5;
  localparam int SEL_LSB = 4;
  localparam int LOWER_MSB = 3;
  localparam int LOWER_LSB = 0;
  localparam int UPPER_MSB = 7;
  localparam int UPPER_LSB = 2;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] LOCK_FREE = 2'h0;
  localparam logic [1:0] LOCK_MANUAL = 2'h1;
  localparam logic [1:0] LOCK_HOLD = 2'h2;
  localparam logic [1:0] LOCK_DETECT = 2'h3;
  localparam logic [1:0] SEL_ROM = 2'h0;
  localparam logic [1:0] SEL_CUSTOM_RX = 2'h1;
  localparam logic [1:0] SEL_CUSTOM_TX = 2'h2;
  localparam logic [1:0] SEL_CUSTOM_BOTH = 2'h3;
  localparam logic [7:0] TX_TABLE_FIRST = 8'h10;
  localparam logic [7:0] TX_TABLE_LAST = 8'h18;
  localparam int TX_TABLE_LEN = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    AGS_PH_IDLE,
    AGS_PH_TX,
    AGS_PH_RX,
    AGS_PH_SLEEP
  } ags_phase_t;
endpackage

// ### logic/ags_table_ram.sv
// small register-output memory holding the transmit loop table copy
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ags_table_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 9,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in && (32'(wr_addr_in) < DEPTH)) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else if (32'(rd_addr_in) < DEPTH) begin
      rd_data_out <= mem_q[rd_addr_in];
    end else begin
      rd_data_out <= '0;
    end
  end
endmodule
`default_nettype wire

// ### logic/ags_config.sv
// gain-lock and synthesizer loop-table configuration register block
// assumes axi4-lite master, packet ram write snoop, radio phase inputs
`timescale 1ns/10ps
`default_nettype none
// Contract
// - gain lock field: 0 free, 1 manual, 2 hold, 3 lock on detection
// - lock-on-detection with preamble match zero locks only on sync word
// - select 0: rom tables both ways, loaded on entering transmit or receive
// - select 1: custom receive table from config fields, rom for transmit
// - select 2: transmit table from packet ram 0x10..0x18, rom receive
// - select 3: custom receive from fields and custom transmit from ram
module ags_config #(
  parameter int TBL_W = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,

  // axi4-lite write address
  input wire logic [13:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,

  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,

  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,

  // axi4-lite read address
  input wire logic [13:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,

  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,

  // radio state and detection events
  input wire logic [1:0] radio_phase_in,
  input wire logic preamble_match_nz_in,
  input wire logic preamble_det_in,
  input wire logic sync_det_in,

  // packet ram write snoop
  input wire logic pkt_wr_en_in,
  input wire logic [7:0] pkt_wr_addr_in,
  input wire logic [TBL_W-1:0] pkt_wr_data_in,

  // transmit table read by the synthesizer
  input wire logic [3:0] tx_tbl_addr_in,
  output logic [TBL_W-1:0] tx_tbl_data_out,

  // controls toward the radio
  output logic [1:0] gain_lock_select_out,
  output logic gain_locked_out,
  output logic gain_manual_out,
  output logic gain_hold_out,
  output logic rx_use_custom_out,
  output logic tx_use_custom_out,
  output logic [9:0] rx_table_code_out,
  output logic rom_load_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [5:0] upper;

    logic aw_have;
    logic [13:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;

    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    logic [1:0] phase;
    logic locked;
    logic rom_load;
    logic tx_stale;
  } ags_state_t;

  ags_state_t s_q;
  ags_state_t s_d;

  logic [1:0] lock_sel;
  logic [1:0] tbl_sel;
  logic in_tbl;
  logic [7:0] tbl_off;
  logic entering;
  logic wr_fire;
  logic wr_hit_cfg;
  logic wr_hit_upper;
  logic wr_hit_status;
  logic wr_lane0;
  logic b_clear;
  logic rd_fire;
  logic rd_clear;
  logic lock_trigger;
  logic in_receive;
  logic in_sleep;
  logic into_tx;
  logic tbl_write;
  logic [31:0] cfg_word;
  logic [31:0] upper_word;
  logic [31:0] status_word;

  assign lock_sel = s_q.cfg[ags_pkg::LOCK_MSB:ags_pkg::LOCK_LSB];
  assign tbl_sel = s_q.cfg[ags_pkg::SEL_MSB:ags_pkg::SEL_LSB];
  assign in_tbl = (pkt_wr_addr_in >= ags_pkg::TX_TABLE_FIRST) &&
                  (pkt_wr_addr_in <= ags_pkg::TX_TABLE_LAST);
  assign tbl_off = pkt_wr_addr_in - ags_pkg::TX_TABLE_FIRST;

  assign entering = (radio_phase_in != s_q.phase) &&
    ((radio_phase_in == 2'(ags_pkg::AGS_PH_TX)) ||
     (radio_phase_in == 2'(ags_pkg::AGS_PH_RX)));

  // ----------------------------------------
  // transmit table copy of packet ram
  // ----------------------------------------
  // copy keeps its contents on sleep though the ram loses them, so stale flag tracks it
  ags_table_ram #(
    .WIDTH(TBL_W),
    .DEPTH(ags_pkg::TX_TABLE_LEN),
    .AW(4)
  ) u_tbl (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .wr_en_in(pkt_wr_en_in && in_tbl),
    .wr_addr_in(tbl_off[3:0]),
    .wr_data_in(pkt_wr_data_in),
    .rd_addr_in(tx_tbl_addr_in),
    .rd_data_out(tx_tbl_data_out)
  );

  // ----------------------------------------
  // bus and radio event decode
  // ----------------------------------------
  // one write at a time: a new pair waits until its response is gone
  assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign b_clear = s_q.bvalid && s_axi_bready_in;
  // only byte lane 0 holds register bits, the other lanes are ignored
  assign wr_hit_cfg = (s_q.awaddr == ags_pkg::ADDR_CFG);
  assign wr_hit_upper = (s_q.awaddr == ags_pkg::ADDR_UPPER);
  assign wr_hit_status = (s_q.awaddr == ags_pkg::ADDR_STATUS);
  assign wr_lane0 = s_q.wstrb[0];

  // a read answers in one cycle; arready stays low while data stand
  assign rd_fire = s_axi_arvalid_in && !s_q.rvalid;
  assign rd_clear = s_q.rvalid && s_axi_rready_in;

  // preamble match zero leaves only the sync word as a trigger
  assign lock_trigger = sync_det_in ||
    (preamble_det_in && preamble_match_nz_in);
  assign in_receive = (radio_phase_in == 2'(ags_pkg::AGS_PH_RX));
  assign in_sleep = (radio_phase_in == 2'(ags_pkg::AGS_PH_SLEEP));
  assign into_tx = (radio_phase_in == 2'(ags_pkg::AGS_PH_TX));
  assign tbl_write = pkt_wr_en_in && in_tbl;

  // read words are built once so the read decode stays a plain mux
  always_comb begin
    cfg_word = '0;
    upper_word = '0;
    status_word = '0;
    cfg_word[7:0] = s_q.cfg;
    upper_word[ags_pkg::UPPER_MSB:ags_pkg::UPPER_LSB] = s_q.upper;
    status_word[3:0] = {s_q.tx_stale, s_q.locked, s_q.phase};
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.phase = radio_phase_in;
    s_d.rom_load = 1'b0;

    // bus write: take address and data in either order
    if (s_axi_awvalid_in && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ags_pkg::RESP_OKAY;
      if (wr_hit_cfg) begin
        if (wr_lane0) begin
          s_d.cfg = s_q.wdata[7:0];
        end
      end else if (wr_hit_upper) begin
        if (wr_lane0) begin
          s_d.upper = s_q.wdata[ags_pkg::UPPER_MSB:ags_pkg::UPPER_LSB];
        end
      end else if (!wr_hit_status) begin
        s_d.bresp = ags_pkg::RESP_SLVERR;
      end
    end
    if (b_clear) begin
      s_d.bvalid = 1'b0;
    end

    // bus read
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ags_pkg::RESP_OKAY;
      s_d.rdata = '0;
      case (s_axi_araddr_in)
        ags_pkg::ADDR_CFG: s_d.rdata = cfg_word;
        ags_pkg::ADDR_UPPER: s_d.rdata = upper_word;
        ags_pkg::ADDR_STATUS: s_d.rdata = status_word;
        default: s_d.rresp = ags_pkg::RESP_SLVERR;
      endcase
    end else if (rd_clear) begin
      s_d.rvalid = 1'b0;
    end

    // gain lock tracking
    case (lock_sel)
      ags_pkg::LOCK_DETECT: begin
        if (lock_trigger) begin
          s_d.locked = 1'b1;
        end
      end
      default: s_d.locked = 1'b0;
    endcase
    // the lock only has meaning while receiving
    if (!in_receive) begin
      s_d.locked = 1'b0;
    end

    // rom table load strobe on entering transmit or receive
    if (entering) begin
      s_d.rom_load = into_tx ? !tbl_sel[1] : !tbl_sel[0];
    end

    // ram contents do not survive sleep; flag until rewritten
    // sleep wins over a same-cycle table write, which is lost anyway
    if (in_sleep) begin
      s_d.tx_stale = 1'b1;
    end else if (tbl_write) begin
      s_d.tx_stale = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // synchronous reset; every field starts from a chosen constant
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.cfg <= ags_pkg::CFG_RESET;
      s_q.upper <= ags_pkg::UPPER_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // handshake readies are combinational from the held flags
  assign s_axi_awready_out = !s_q.aw_have;
  assign s_axi_wready_out = !s_q.w_have;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_arready_out = !s_q.rvalid;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;

  assign gain_lock_select_out = lock_sel;
  assign gain_manual_out = (lock_sel == ags_pkg::LOCK_MANUAL);
  assign gain_hold_out = (lock_sel == ags_pkg::LOCK_HOLD) ||
                         s_q.locked;
  assign gain_locked_out = s_q.locked;

  assign rx_use_custom_out = tbl_sel[0];
  assign tx_use_custom_out = tbl_sel[1];
  // fields are only meaningful with custom receive, so gate them to zero
  assign rx_table_code_out = tbl_sel[0] ?
    {s_q.upper, s_q.cfg[ags_pkg::LOWER_MSB:ags_pkg::LOWER_LSB]} :
    10'h000;
  assign rom_load_out = s_q.rom_load;
endmodule
`default_nettype wire

// ### testbench/ags_config_monitor.sv
// assertions on the configuration block ports
// assumes it is bound into ags_config, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ags_config_monitor (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [1:0] radio_phase_in,
  input wire logic preamble_match_nz_in,
  input wire logic preamble_det_in,
  input wire logic sync_det_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [1:0] gain_lock_select_out,
  input wire logic gain_locked_out,
  input wire logic gain_manual_out,
  input wire logic gain_hold_out,
  input wire logic rx_use_custom_out,
  input wire logic tx_use_custom_out,
  input wire logic [9:0] rx_table_code_out,
  input wire logic rom_load_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_rx_detect;
    gain_lock_select_out == 2'h3 && radio_phase_in == 2'h2 &&
    (sync_det_in || (preamble_det_in && preamble_match_nz_in));
  endsequence
  sequence s_enter_tx;
    $changed(radio_phase_in) && radio_phase_in == 2'h1;
  endsequence
  sequence s_enter_rx;
    $changed(radio_phase_in) && radio_phase_in == 2'h2;
  endsequence
  a_manual_mode: assert property (
    gain_manual_out == (gain_lock_select_out == 2'h1)) else $error("manual");
  a_hold_mode: assert property (
    gain_lock_select_out == 2'h2 |-> gain_hold_out) else $error("hold");
  a_lock_detect: assert property (
    s_rx_detect |=> gain_locked_out) else $error("no lock");
  a_lock_sync_only: assert property (
    gain_lock_select_out == 2'h3 && preamble_det_in && !sync_det_in &&
    !preamble_match_nz_in && !gain_locked_out |=> !gain_locked_out)
    else $error("locked on preamble");
  a_rom_tx_load: assert property (
    s_enter_tx ##0 !tx_use_custom_out |=> rom_load_out) else $error("tx load");
  a_rom_rx_load: assert property (
    s_enter_rx ##0 !rx_use_custom_out |=> rom_load_out) else $error("rx load");
  a_custom_tx_noload: assert property (
    s_enter_tx ##0 tx_use_custom_out |=> !rom_load_out) else $error("tx rom");
  a_rx_code_zero: assert property (
    !rx_use_custom_out |-> rx_table_code_out == 10'h000) else $error("code");
  a_bvalid_stands: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("b");
  a_rvalid_stands: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out) else $error("r");
endmodule
bind ags_config ags_config_monitor ags_config_monitor_inst (.*);
`default_nettype wire

// ### testbench/radio_agc_synth_lut_config_bench.sv
// self-checking bench for the gain-lock and loop-table register block
// assumes ags_config with its monitor bound in
`timescale 1ns/10ps
`default_nettype none
module radio_agc_synth_lut_config_bench;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [13:0] s_axi_awaddr_in = 14'h0000, s_axi_araddr_in = 14'h0000;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0;
  // ready lines rise only once an answer shows, so answers must stand
  logic s_axi_bready_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic [1:0] radio_phase_in = 2'h0;
  logic preamble_match_nz_in = 1'b0, preamble_det_in = 1'b0;
  logic sync_det_in = 1'b0, pkt_wr_en_in = 1'b0;
  logic [7:0] pkt_wr_addr_in = 8'h00, pkt_wr_data_in = 8'h00;
  logic [3:0] tx_tbl_addr_in = 4'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, gain_locked_out;
  logic gain_manual_out, gain_hold_out, rx_use_custom_out;
  logic tx_use_custom_out, rom_load_out, seen;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, gain_lock_select_out, rsp;
  logic [31:0] s_axi_rdata_out, rd;
  logic [7:0] tx_tbl_data_out;
  logic [9:0] rx_table_code_out;
  int n_fail = 0, comparisons = 0, cycles = 0;
  ags_config #(.TBL_W(8)) ags_config_inst (.*);
  always #4 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (!(aw && w)) begin
      tick(1);
      if (!aw && s_axi_awready_out) begin
        aw = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w && s_axi_wready_out) begin
        w = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do tick(1); while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b1;
    tick(1);
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rdr(input logic [13:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do tick(1); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do tick(1); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b1;
    tick(1);
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic det(input logic p, input logic s);
    preamble_det_in <= p;
    sync_det_in <= s;
    tick(1);
    preamble_det_in <= 1'b0;
    sync_det_in <= 1'b0;
    tick(1);
  endtask
  task automatic enter(input logic [1:0] p);
    seen = 1'b0;
    radio_phase_in <= p;
    repeat (3) begin
      tick(1);
      seen = seen | rom_load_out;
    end
  endtask
  task automatic fill();
    for (int i = 0; i < ags_pkg::TX_TABLE_LEN; i++) begin
      pkt_wr_en_in <= 1'b1;
      pkt_wr_addr_in <= ags_pkg::TX_TABLE_FIRST + 8'(i);
      pkt_wr_data_in <= 8'h30 + 8'(i);
      tick(1);
    end
    pkt_wr_en_in <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    rdr(ags_pkg::ADDR_CFG);
    chk(rd, {24'h0, ags_pkg::CFG_RESET});
    chk(32'(rsp), 32'(ags_pkg::RESP_OKAY));
    rdr(14'h0004);
    chk(32'(rsp), 32'(ags_pkg::RESP_SLVERR));
    chk(rd, 32'h00000000);
    wr(14'h0004, 32'h000000FF);
    chk(32'(rsp), 32'(ags_pkg::RESP_SLVERR));
    wr(ags_pkg::ADDR_STATUS, 32'h000000FF);
    chk(32'(rsp), 32'(ags_pkg::RESP_OKAY));
    wr(ags_pkg::ADDR_CFG, 32'h000000A5);
    chk(32'(rsp), 32'(ags_pkg::RESP_OKAY));
    rdr(ags_pkg::ADDR_CFG);
    chk(rd, 32'h000000A5);
    $display("test regs done");
  endtask
  task automatic test_lock();
    for (int m = 0; m < 4; m++) begin
      wr(ags_pkg::ADDR_CFG, {24'h0, 2'(m), 6'h00});
      chk(32'(gain_lock_select_out), 32'(m));
      chk(32'(gain_manual_out), 32'(m == 1));
      chk(32'(gain_hold_out), 32'(m == 2));
    end
    radio_phase_in <= 2'h2;
    tick(2);
    det(1'b1, 1'b0);
    chk(32'(gain_locked_out), 32'h0);
    det(1'b0, 1'b1);
    chk(32'(gain_locked_out), 32'h1);
    chk(32'(gain_hold_out), 32'h1);
    radio_phase_in <= 2'h0;
    preamble_match_nz_in <= 1'b1;
    tick(2);
    radio_phase_in <= 2'h2;
    tick(2);
    det(1'b1, 1'b0);
    chk(32'(gain_locked_out), 32'h1);
    radio_phase_in <= 2'h0;
    tick(2);
    $display("test lock done");
  endtask
  task automatic test_tables();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(ags_pkg::ADDR_UPPER, s[0] ? 32'hA8 : 32'h0);
      wr(ags_pkg::ADDR_CFG, {26'h0, s, s[0] ? 4'h5 : 4'h0});
      chk(32'(rx_use_custom_out), 32'(s[0]));
      chk(32'(tx_use_custom_out), 32'(s[1]));
      chk(32'(rx_table_code_out), s[0] ? 32'h2A5 : 32'h0);
      enter(2'h1);
      chk(32'(seen), 32'(!s[1]));
      enter(2'h2);
      chk(32'(seen), 32'(!s[0]));
      enter(2'h0);
    end
    $display("test tables done");
  endtask
  task automatic test_tx_ram();
    fill();
    for (int i = 0; i < ags_pkg::TX_TABLE_LEN; i++) begin
      tx_tbl_addr_in <= 4'(i);
      tick(2);
      chk(32'(tx_tbl_data_out), 32'h30 + 32'(i));
    end
    enter(2'h3);
    enter(2'h0);
    rdr(ags_pkg::ADDR_STATUS);
    chk(32'(rd[3]), 32'h1);
    fill();
    rdr(ags_pkg::ADDR_STATUS);
    chk(32'(rd[3]), 32'h0);
    $display("test tx ram done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    tick(12);
    reset_in <= 1'b0;
    tick(1);
    test_regs();
    test_lock();
    test_tables();
    test_tx_ram();
    results();
  end
endmodule
`default_nettype wire
